// ### hw/timing_ctrl_pkg.sv
// Purpose: shared constants for the reference and mode control block
// Assumes: 250 MHz system clock, plain register port with 8-bit data
// Notes:   timing counts are derived from times given in their own units
package timing_ctrl_pkg;
   // system clock
   localparam int CLK_HZ        = 250_000_000;
   localparam int CLK_PERIOD_PS = 4_000;

   // frame timing, times in ns, counts in clock cycles
   localparam int FRAME_PERIOD_NS = 125_000;
   localparam int FP_W122_NS      = 122;
   localparam int FP_W244_NS      = 244;
   localparam int FP_W61_NS       = 61;
   localparam int FRAME_CYC = FRAME_PERIOD_NS * 1000 / CLK_PERIOD_PS;
   localparam int FP_W122_CYC = (FP_W122_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FP_W244_CYC = (FP_W244_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FP_W61_CYC  = (FP_W61_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // supported reference rates and deviation limits
   localparam int FREQ_8K_HZ    = 8_000;
   localparam int FREQ_1M544_HZ = 1_544_000;
   localparam int FREQ_2M048_HZ = 2_048_000;
   localparam int FREQ_19M44_HZ = 19_440_000;
   localparam int PPM_TRACK     = 104;
   localparam int PPM_RANGE     = 12;
   localparam int PPM_SCALE     = 1_000_000;

   // detected reference class
   localparam logic [1:0] CLS_8K    = 2'h0;
   localparam logic [1:0] CLS_1M544 = 2'h1;
   localparam logic [1:0] CLS_2M048 = 2'h2;
   localparam logic [1:0] CLS_19M44 = 2'h3;

   // operating mode, gray along normal-holdover-freerun
   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'h0,
      MODE_HOLDOVER = 2'h1,
      MODE_FREERUN  = 2'h3
   } op_mode_t;

   // mode pin codes {mode_select_b, mode_select_a}
   localparam logic [1:0] MS_HOLDOVER = 2'h1;
   localparam logic [1:0] MS_FREERUN  = 2'h2;

   // register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_MASK   = 4'h4;
   localparam logic [3:0] OFS_STATE  = 4'h8;
   localparam logic [3:0] OFS_CLASS  = 4'hC;

   // status bits
   localparam int ST_LOCK_LOST = 0;
   localparam int ST_PRI_OOR   = 1;
   localparam int ST_SEC_OOR   = 2;
   localparam int ST_REALIGN   = 3;
   localparam int ST_MODE_CHG  = 4;
   localparam int ST_W         = 5;

   // synchronised pin vector layout
   localparam int PIN_SEL   = 0;
   localparam int PIN_MSA   = 1;
   localparam int PIN_MSB   = 2;
   localparam int PIN_ALIGN = 3;
   localparam int PIN_OE    = 4;
   localparam int PIN_EN19  = 5;
   localparam int PIN_EN77  = 6;
   localparam int PIN_W     = 7;
endpackage : timing_ctrl_pkg

// ### hw/ref_meter.sv
// Purpose: classify one reference input and flag its deviation
// Assumes: reference is asynchronous and well below half the clock rate
// Notes:   one gate window of edges decides class, range and track flags
`timescale 1ns/1ps
module ref_meter
   import timing_ctrl_pkg::*;
#(
   parameter int unsigned GATE_CYCLES = CLK_HZ
)
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   // reference pin
   input  wire logic       i_ref,
   // results
   output logic            o_edge,
   output logic [1:0]      o_class,
   output logic            o_valid,
   output logic            o_out_of_range
);
   import timing_ctrl_pkg::*;

   localparam longint GL = longint'(GATE_CYCLES);
   localparam longint FL [4] = '{FREQ_8K_HZ, FREQ_1M544_HZ, FREQ_2M048_HZ, FREQ_19M44_HZ};
   localparam logic [31:0] NOM [4] = '{
      32'(GL * FL[0] / CLK_HZ), 32'(GL * FL[1] / CLK_HZ),
      32'(GL * FL[2] / CLK_HZ), 32'(GL * FL[3] / CLK_HZ)};
   localparam logic [31:0] TRK [4] = '{
      32'(longint'(NOM[0]) * PPM_TRACK / PPM_SCALE),
      32'(longint'(NOM[1]) * PPM_TRACK / PPM_SCALE),
      32'(longint'(NOM[2]) * PPM_TRACK / PPM_SCALE),
      32'(longint'(NOM[3]) * PPM_TRACK / PPM_SCALE)};
   localparam logic [31:0] RNG [4] = '{
      32'(longint'(NOM[0]) * PPM_RANGE / PPM_SCALE),
      32'(longint'(NOM[1]) * PPM_RANGE / PPM_SCALE),
      32'(longint'(NOM[2]) * PPM_RANGE / PPM_SCALE),
      32'(longint'(NOM[3]) * PPM_RANGE / PPM_SCALE)};
   localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);

   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        s3;
      logic [31:0] gate_cnt;
      logic [31:0] edge_cnt;
      logic [1:0]  cls;
      logic        valid;
      logic        oor;
      logic        edge_p;
   } meter_t;

   meter_t s_reg;
   meter_t s_next;

   // edge pick, gate counting and classification
   always_comb
   begin
      logic        rise;
      logic        fall;
      logic [31:0] cnt;
      logic [31:0] diff;
      rise = 1'b0;
      fall = 1'b0;
      cnt  = '0;
      diff = '0;
      s_next    = s_reg;
      s_next.s1 = i_ref;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      rise = s_reg.s2 & ~s_reg.s3;
      fall = ~s_reg.s2 & s_reg.s3;
      // rising edge for the fast rate, falling for the others
      s_next.edge_p = (s_reg.cls == CLS_19M44) ? rise : fall;
      cnt = s_reg.edge_cnt + {31'h0, rise};
      if (s_reg.gate_cnt == GATE_LAST)
      begin
         s_next.gate_cnt = '0;
         s_next.edge_cnt = '0;
         s_next.valid    = 1'b0;
         s_next.oor      = 1'b1;
         // pick whichever nominal rate the count sits near
         for (int k = 0; k < 4; k++)
         begin
            diff = (cnt >= NOM[k]) ? cnt - NOM[k] : NOM[k] - cnt;
            if (diff <= TRK[k])
            begin
               s_next.cls   = 2'(k);
               s_next.valid = 1'b1;
               s_next.oor   = (diff > RNG[k]);
            end
         end
      end
      else
      begin
         s_next.gate_cnt = s_reg.gate_cnt + 32'h1;
         s_next.edge_cnt = cnt;
      end
   end

   // state register, out of range until the first gate ends
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         s_reg     <= '0;
         s_reg.s1  <= 1'b1; // start at the pulled-up idle level, no false rise
         s_reg.s2  <= 1'b1;
         s_reg.s3  <= 1'b1;
         s_reg.oor <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   assign o_edge         = s_reg.edge_p;
   assign o_class        = s_reg.cls;
   assign o_valid        = s_reg.valid;
   assign o_out_of_range = s_reg.oor;
endmodule : ref_meter

// ### hw/timing_ref_ctrl.sv
// Purpose: reference select, mode, indicators and output gating
// Assumes: i_clock stands in for the master oscillator, 250 MHz
// Notes:   control and reference pins pass two flops before use, register port pins do not; outputs are registered
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module timing_ref_ctrl
   import timing_ctrl_pkg::*;
#(
   parameter int unsigned FRAME_CYCLES = FRAME_CYC,
   parameter int unsigned GATE_CYCLES  = CLK_HZ
)
(
   // clock and reset
   input  wire logic                            i_clock,
   input  wire logic                            i_resetn,
   // reference pins
   input  wire logic                            i_primary_ref_in,
   input  wire logic                            i_secondary_ref_in,
   // control pins
   input  wire logic                            i_ref_source_select,
   input  wire logic                            i_mode_select_a,
   input  wire logic                            i_mode_select_b,
   input  wire logic                            i_phase_realign_in,
   input  wire logic                            i_output_enable,
   input  wire logic                            i_lowjitter_19m_enable,
   input  wire logic                            i_lowjitter_77m_enable,
   // register port
   input  wire logic [timing_ctrl_pkg::ADDR_W-1:0] i_reg_addr,
   input  wire logic [timing_ctrl_pkg::DATA_W-1:0] i_reg_wdata,
   input  wire logic                            i_reg_write,
   input  wire logic                            i_reg_read,
   output logic [timing_ctrl_pkg::DATA_W-1:0]   o_reg_rdata,
   // indicators
   output logic                                 o_lock,
   output logic                                 o_holdover,
   output logic                                 o_primary_out_of_range,
   output logic                                 o_secondary_out_of_range,
   output logic                                 o_irq,
   // frame pulses, active low
   output logic                                 o_frame_pulse_8k_122ns_n,
   output logic                                 o_frame_pulse_8k_244ns_n,
   output logic                                 o_frame_pulse_8k_61ns_n,
   // output drive enables
   output logic                                 o_clock_outputs_oe,
   output logic                                 o_lowjitter_19m_out_oe,
   output logic                                 o_lowjitter_77m_diff_out_oe
);
   import timing_ctrl_pkg::*;

   localparam logic [31:0] FRAME_LAST = 32'(FRAME_CYCLES - 1);
   localparam logic [31:0] W122 = 32'(FP_W122_CYC);
   localparam logic [31:0] W244 = 32'(FP_W244_CYC);
   localparam logic [31:0] W61  = 32'(FP_W61_CYC);

   typedef struct packed {
      logic [PIN_W-1:0]  pin_s1;
      logic [PIN_W-1:0]  pin_s2;
      logic              align_s3;
      logic [31:0]       frame_cnt;
      logic              fp122_n;
      logic              fp244_n;
      logic              fp61_n;
      logic              ref_sel;
      op_mode_t          mode;
      logic              realign_pend;
      logic              lock;
      logic              holdover;
      logic              pri_oor;
      logic              sec_oor;
      logic              clk_oe;
      logic              j19_oe;
      logic              j77_oe;
      logic [ST_W-1:0]   status;
      logic [ST_W-1:0]   mask;
      logic [DATA_W-1:0] rdata;
      logic              irq;
   } ctrl_t;

   ctrl_t s_reg;
   ctrl_t s_next;

   logic       pri_edge;
   logic       sec_edge;
   logic [1:0] pri_cls;
   logic [1:0] sec_cls;
   logic       pri_valid;
   logic       sec_valid;
   logic       pri_oor_w;
   logic       sec_oor_w;

   // one meter per reference input
   ref_meter #(
      .GATE_CYCLES    (GATE_CYCLES)
   ) u_pri_meter (
      .i_clock        (i_clock),
      .i_resetn       (i_resetn),
      .i_ref          (i_primary_ref_in),
      .o_edge         (pri_edge),
      .o_class        (pri_cls),
      .o_valid        (pri_valid),
      .o_out_of_range (pri_oor_w)
   );

   ref_meter #(
      .GATE_CYCLES    (GATE_CYCLES)
   ) u_sec_meter (
      .i_clock        (i_clock),
      .i_resetn       (i_resetn),
      .i_ref          (i_secondary_ref_in),
      .o_edge         (sec_edge),
      .o_class        (sec_cls),
      .o_valid        (sec_valid),
      .o_out_of_range (sec_oor_w)
   );

   // next state of the whole control block
   always_comb
   begin
      logic             sel_edge;
      logic             sel_valid;
      logic             align_fall;
      logic             wr_status;
      logic [ST_W-1:0]  ev;
      logic [ST_W-1:0]  clr;
      op_mode_t         new_mode;
      sel_edge   = 1'b0;
      sel_valid  = 1'b0;
      align_fall = 1'b0;
      wr_status  = 1'b0;
      ev         = '0;
      clr        = '0;
      new_mode   = MODE_NORMAL;
      s_next     = s_reg;

      // two-flop pin synchronisers
      s_next.pin_s1 = {i_lowjitter_77m_enable, i_lowjitter_19m_enable,
                       i_output_enable, i_phase_realign_in,
                       i_mode_select_b, i_mode_select_a, i_ref_source_select};
      s_next.pin_s2   = s_reg.pin_s1;
      s_next.align_s3 = s_reg.pin_s2[PIN_ALIGN];

      // active edge of the chosen reference
      sel_edge  = s_reg.ref_sel ? sec_edge : pri_edge;
      sel_valid = s_reg.ref_sel ? sec_valid : pri_valid;

      // free running frame counter
      if (s_reg.frame_cnt == FRAME_LAST)
         s_next.frame_cnt = '0;
      else
         s_next.frame_cnt = s_reg.frame_cnt + 32'h1;

      // realign waits for the next reference edge in normal mode
      align_fall = s_reg.align_s3 & ~s_reg.pin_s2[PIN_ALIGN];
      if (s_reg.realign_pend && sel_edge && s_reg.mode == MODE_NORMAL)
      begin
         s_next.frame_cnt    = '0;
         s_next.realign_pend = 1'b0;
         ev[ST_REALIGN]      = 1'b1;
      end
      if (align_fall)
         s_next.realign_pend = 1'b1;

      // frame pulses low at the start of each frame
      s_next.fp122_n = ~(s_next.frame_cnt < W122);
      s_next.fp244_n = ~(s_next.frame_cnt < W244);
      s_next.fp61_n  = ~(s_next.frame_cnt < W61);

      // mode pin decode
      case ({s_reg.pin_s2[PIN_MSB], s_reg.pin_s2[PIN_MSA]})
         MS_HOLDOVER: new_mode = MODE_HOLDOVER;
         MS_FREERUN:  new_mode = MODE_FREERUN;
         default:     new_mode = MODE_NORMAL;
      endcase

      // sample select and mode on the rise of the 122 ns pulse
      if (!s_reg.fp122_n && s_next.fp122_n)
      begin
         s_next.ref_sel = s_reg.pin_s2[PIN_SEL];
         s_next.mode    = new_mode;
         ev[ST_MODE_CHG] = (new_mode != s_reg.mode);
      end

      // indicators
      s_next.lock     = (s_reg.mode == MODE_NORMAL) && sel_valid;
      s_next.holdover = (s_reg.mode == MODE_HOLDOVER);
      s_next.pri_oor  = pri_oor_w;
      s_next.sec_oor  = sec_oor_w;
      ev[ST_LOCK_LOST] = s_reg.lock & ~s_next.lock;
      ev[ST_PRI_OOR]   = ~s_reg.pri_oor & pri_oor_w;
      ev[ST_SEC_OOR]   = ~s_reg.sec_oor & sec_oor_w;

      // output drive enables
      s_next.clk_oe = s_reg.pin_s2[PIN_OE];
      s_next.j19_oe = s_reg.pin_s2[PIN_EN19];
      s_next.j77_oe = s_reg.pin_s2[PIN_EN77];

      // register writes, status clears by writing ones
      wr_status = i_reg_write && (i_reg_addr == OFS_STATUS);
      clr = wr_status ? i_reg_wdata[ST_W-1:0] : '0;
      if (i_reg_write && i_reg_addr == OFS_MASK)
         s_next.mask = i_reg_wdata[ST_W-1:0];
      // a new event wins over a clear in the same cycle
      s_next.status = (s_reg.status & ~clr) | ev;
      s_next.irq    = |(s_next.status & s_next.mask);

      // register reads, data valid the following cycle only
      s_next.rdata = '0;
      if (i_reg_read)
      begin
         case (i_reg_addr)
            OFS_STATUS: s_next.rdata = DATA_W'(s_reg.status);
            OFS_MASK:   s_next.rdata = DATA_W'(s_reg.mask);
            OFS_STATE:  s_next.rdata = {1'b0, s_reg.sec_oor, s_reg.pri_oor,
                                        s_reg.holdover, s_reg.lock,
                                        s_reg.ref_sel, s_reg.mode};
            OFS_CLASS:  s_next.rdata = {2'h0, sec_valid, pri_valid,
                                        sec_cls, pri_cls};
            default:    s_next.rdata = '0;
         endcase
      end
   end

   // state register; select flops clear so primary is the default
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         s_reg         <= '0;
         s_reg.frame_cnt <= FRAME_LAST; // first edge after release opens a full frame
         s_reg.fp122_n <= 1'b1;
         s_reg.fp244_n <= 1'b1;
         s_reg.fp61_n  <= 1'b1;
         s_reg.pri_oor <= 1'b1;
         s_reg.sec_oor <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   // outputs straight from the state register
   assign o_reg_rdata                 = s_reg.rdata;
   assign o_lock                      = s_reg.lock;
   assign o_holdover                  = s_reg.holdover;
   assign o_primary_out_of_range      = s_reg.pri_oor;
   assign o_secondary_out_of_range    = s_reg.sec_oor;
   assign o_irq                       = s_reg.irq;
   assign o_frame_pulse_8k_122ns_n    = s_reg.fp122_n;
   assign o_frame_pulse_8k_244ns_n    = s_reg.fp244_n;
   assign o_frame_pulse_8k_61ns_n     = s_reg.fp61_n;
   assign o_clock_outputs_oe          = s_reg.clk_oe;
   assign o_lowjitter_19m_out_oe      = s_reg.j19_oe;
   assign o_lowjitter_77m_diff_out_oe = s_reg.j77_oe;

   // helper: length of the last 122 ns low pulse
   logic [7:0] low_len;
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
         low_len <= '0;
      else if (!s_reg.fp122_n)
         low_len <= low_len + 8'h1;
      else
         low_len <= '0;
   end

   // select changes only with the frame pulse rise
   property p_sel_capture;
      @(posedge i_clock) disable iff (!i_resetn)
      $changed(s_reg.ref_sel) |-> $rose(s_reg.fp122_n);
   endproperty
   a_sel_capture: assert property (p_sel_capture)
      else $error("select changed off the frame pulse");

   // mode changes only with the frame pulse rise
   property p_mode_capture;
      @(posedge i_clock) disable iff (!i_resetn)
      $changed(s_reg.mode) |-> $rose(s_reg.fp122_n) && s_reg.status[ST_MODE_CHG];
   endproperty
   a_mode_capture: assert property (p_mode_capture)
      else $error("mode changed off the frame pulse");

   // frame pulse low for exactly the 122 ns count
   property p_pulse_width;
      @(posedge i_clock) disable iff (!i_resetn)
      $rose(s_reg.fp122_n) && !$past(i_resetn) == 1'b0 |-> low_len == 8'(FP_W122_CYC);
   endproperty
   a_pulse_width: assert property (p_pulse_width)
      else $error("122 ns frame pulse has wrong width");

   // align falling edge arms the realign
   property p_align_arm;
      @(posedge i_clock) disable iff (!i_resetn)
      $fell(s_reg.pin_s2[PIN_ALIGN]) |=> s_reg.realign_pend;
   endproperty
   a_align_arm: assert property (p_align_arm)
      else $error("align edge did not arm realign");

   // realign restarts the frame only on the chosen reference edge
   property p_realign_edge;
      @(posedge i_clock) disable iff (!i_resetn)
      $fell(s_reg.realign_pend) |->
         s_reg.frame_cnt == 32'h0 && $past(s_reg.ref_sel ? sec_edge : pri_edge);
   endproperty
   a_realign_edge: assert property (p_realign_edge)
      else $error("realign without the selected reference edge");

   // lock only in normal mode
   property p_lock_mode;
      @(posedge i_clock) disable iff (!i_resetn)
      o_lock |-> $past(s_reg.mode) == MODE_NORMAL;
   endproperty
   a_lock_mode: assert property (p_lock_mode)
      else $error("lock outside normal mode");

   // holdover indicator follows the mode one cycle later
   property p_holdover;
      @(posedge i_clock) disable iff (!i_resetn)
      ##1 o_holdover == ($past(s_reg.mode) == MODE_HOLDOVER);
   endproperty
   a_holdover: assert property (p_holdover)
      else $error("holdover indicator wrong");

   // primary out of range tracks its meter
   property p_pri_oor;
      @(posedge i_clock) disable iff (!i_resetn)
      ##1 o_primary_out_of_range == $past(pri_oor_w);
   endproperty
   a_pri_oor: assert property (p_pri_oor)
      else $error("primary out of range wrong");

   // secondary out of range tracks its meter
   property p_sec_oor;
      @(posedge i_clock) disable iff (!i_resetn)
      ##1 o_secondary_out_of_range == $past(sec_oor_w);
   endproperty
   a_sec_oor: assert property (p_sec_oor)
      else $error("secondary out of range wrong");

   // general enable reaches the drive enable three edges after the pin
   property p_clk_oe;
      @(posedge i_clock) disable iff (!i_resetn)
      $rose(i_output_enable) ##1 i_output_enable[*2] |=> o_clock_outputs_oe;
   endproperty
   a_clk_oe: assert property (p_clk_oe)
      else $error("clock outputs not enabled");

   // low jitter enables follow their pins
   property p_j19_oe;
      @(posedge i_clock) disable iff (!i_resetn)
      !i_lowjitter_19m_enable[*4] |=> !o_lowjitter_19m_out_oe;
   endproperty
   a_j19_oe: assert property (p_j19_oe)
      else $error("19 MHz output not disabled");

   property p_j77_oe;
      @(posedge i_clock) disable iff (!i_resetn)
      i_lowjitter_77m_enable[*4] |=> o_lowjitter_77m_diff_out_oe;
   endproperty
   a_j77_oe: assert property (p_j77_oe)
      else $error("77 MHz output not enabled");

   // main scenarios
   c_realign:  cover property (@(posedge i_clock) $fell(s_reg.realign_pend));
   c_holdover: cover property (@(posedge i_clock) $rose(o_holdover));
   c_lock:     cover property (@(posedge i_clock) $rose(o_lock));
   c_sel_sec:  cover property (@(posedge i_clock) $rose(s_reg.ref_sel));
endmodule : timing_ref_ctrl

// ### tb/ref_source_model.sv
// Purpose: board-side reference source feeding one reference pin
// Assumes: free running square wave, asynchronous to the system clock
// Notes:   half period and start offset in ps are set by the bench
`timescale 1ns/1ps
module ref_source_model
#(
   parameter int unsigned HALF_PS  = 25720,
   parameter int unsigned PHASE_PS = 1300
)
(
   // reference pin
   output logic o_ref
);
   // square wave; at the default half period and offset its edges never align with the system clock
   initial
   begin
      o_ref = 1'b1;
      #(PHASE_PS * 1ps);
      forever
      begin
         #(HALF_PS * 1ps) o_ref = ~o_ref;
      end
   end
endmodule : ref_source_model

// ### tb/testbench.sv
// Purpose: self-checking bench for reference and mode control
// Assumes: shortened frame and gate counts, 250 MHz clock
// Notes:   pins and register port driven by non-blocking assignment
`timescale 1ns/1ps
module testbench;
   import timing_ctrl_pkg::*;
   logic       i_clock  = 1'b0;
   logic       i_resetn = 1'b0;
   logic       primary_ref_in, sec, sel = 1'b0, msa = 1'b0, msb = 1'b0, aln = 1'b1;
   logic       oe = 1'b0, en19 = 1'b0, en77 = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0] addr  = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, d;
   logic       lock, hold, poor, soor, irq, fp122, fp244, fp61, coe, oe19, oe77;
   logic [7:0] mexp [4] = '{8'h04, 8'h15, 8'h07, 8'h04};
   int         errors = 0, n_tests = 0, cyc = 0, k, code;

   // 250 MHz clock
   always #2 i_clock = ~i_clock;

   // far-side reference sources
   ref_source_model u_pri (.o_ref(primary_ref_in));
   ref_source_model #(.HALF_PS(244140), .PHASE_PS(700)) u_sec (.o_ref(sec));

   timing_ref_ctrl #(.FRAME_CYCLES(250), .GATE_CYCLES(12500)) uut (
      .i_clock(i_clock), .i_resetn(i_resetn),
      .i_primary_ref_in(primary_ref_in), .i_secondary_ref_in(sec),
      .i_ref_source_select(sel), .i_mode_select_a(msa), .i_mode_select_b(msb),
      .i_phase_realign_in(aln), .i_output_enable(oe),
      .i_lowjitter_19m_enable(en19), .i_lowjitter_77m_enable(en77),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd),
      .o_reg_rdata(rdata), .o_lock(lock), .o_holdover(hold),
      .o_primary_out_of_range(poor), .o_secondary_out_of_range(soor), .o_irq(irq),
      .o_frame_pulse_8k_122ns_n(fp122), .o_frame_pulse_8k_244ns_n(fp244),
      .o_frame_pulse_8k_61ns_n(fp61), .o_clock_outputs_oe(coe),
      .o_lowjitter_19m_out_oe(oe19), .o_lowjitter_77m_diff_out_oe(oe77));

   // compare and count
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk

   // wait n edges, then settle
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : cyc_wait

   // one-cycle register write
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clock);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge i_clock);
      wr    <= 1'b0;
   endtask : reg_wr

   // one-cycle register read, data in the following cycle
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge i_clock);
      rd   <= 1'b1;
      addr <= a;
      @(posedge i_clock);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask : reg_rd

   // cycles until the 122 ns pulse reaches a level
   task automatic fp_edge(input logic lvl, output int n);
      n = 0;
      while (fp122 !== lvl && n < 400)
      begin
         cyc_wait(1);
         n++;
      end
   endtask : fp_edge

   // verdict and end of run
   task automatic summarize;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   // hang guard
   always @(posedge i_clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         errors++;
         summarize();
      end
   end

   // main sequence
   initial
   begin
      cyc_wait(5);
      chk({fp122, fp244, fp61, poor, soor, lock, hold, irq}, 8'hF8);
      i_resetn <= 1'b1;
      fp_edge(1'b0, k);
      fp_edge(1'b1, k);
      chk(8'(k), 8'h1F);
      sel <= 1'b1;
      msa <= 1'b1;
      reg_wr(OFS_MASK, 8'h10);
      cyc_wait(100);
      reg_rd(OFS_STATE, d);
      chk(d & 8'h17, 8'h00);
      fp_edge(1'b0, k);
      chk(8'(k + 135), 8'hFA);
      for (int j = 1; j < 5; j++)
      begin
         code = j % 4;
         {msb, msa} <= 2'(code);
         fp_edge(1'b0, k);
         fp_edge(1'b1, k);
         chk({6'h00, fp244, fp61}, 8'h01);
         cyc_wait(3);
         reg_rd(OFS_STATE, d);
         chk(d & 8'h17, mexp[code]);
         chk({7'h00, hold}, {7'h00, mexp[code][4]});
      end
      chk({7'h00, irq}, 8'h01);
      reg_rd(OFS_MASK, d);
      chk(d, 8'h10);
      reg_rd(4'h2, d);
      chk(d, 8'h00);
      reg_wr(OFS_STATUS, 8'h10);
      cyc_wait(2);
      chk({7'h00, irq}, 8'h00);
      aln <= 1'b0;
      cyc_wait(150);
      reg_rd(OFS_STATUS, d);
      chk(d & 8'h18, 8'h08);
      chk({7'h00, irq}, 8'h00);
      oe   <= 1'b1;
      en19 <= 1'b1;
      cyc_wait(4);
      chk({5'h00, coe, oe19, oe77}, 8'h06);
      oe   <= 1'b0;
      en19 <= 1'b0;
      en77 <= 1'b1;
      cyc_wait(4);
      chk({5'h00, coe, oe19, oe77}, 8'h01);
      i_resetn <= 1'b0;
      cyc_wait(250);
      chk({fp122, fp244, fp61, poor, soor, lock, hold, irq}, 8'hF8);
      i_resetn <= 1'b1;
      cyc_wait(1);
      chk({5'h00, fp122, fp244, fp61}, 8'h00);
      reg_rd(OFS_STATE, d);
      chk(d & 8'h17, 8'h00);
      reg_rd(OFS_MASK, d);
      chk(d, 8'h00);
      summarize();
   end
endmodule : testbench
